// *** hdl/swt_pkg.sv ***
// stopwatch timer package: register indices, field positions, reset
// values and timing counts shared by the stopwatch design files.
// assumes a single 25 MHz core clock and a word-wide avalon bus.
package swt_pkg;

    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int unsigned CORE_CLK_HZ = 25000000;
    localparam int unsigned SRC_CLK_HZ = 256; // internal source rate
    // longest whole period of the source, in core cycles (rounded down)
    localparam int unsigned SRC_DIV_CYCLES = CORE_CLK_HZ / SRC_CLK_HZ;
    localparam int unsigned STEP_HZ = 100; // hundredths rate
    localparam logic [7:0] STEP_INC = 8'(STEP_HZ);
    localparam logic [3:0] BCD_MAX = 4'h9;

    // ****************************************************************
    // bus and register map (index; byte address is four times it)
    // ****************************************************************
    localparam int unsigned AV_ADDR_W = 18;
    localparam logic [15:0] IDX_PRIORITY = 16'hff20;
    localparam logic [15:0] IDX_ENABLE = 16'hff22;
    localparam logic [15:0] IDX_FLAGS = 16'hff24;
    localparam logic [15:0] IDX_CONTROL = 16'hff42;
    localparam logic [15:0] IDX_COUNT = 16'hff43;

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int unsigned CTL_RUN_POS = 0;
    localparam int unsigned CTL_CLR_POS = 1;
    localparam int unsigned PRI_LSB = 2;
    localparam int unsigned IRQ_LSB = 4; // 1 Hz at 4, 10 Hz 5, 100 Hz 6
    localparam logic [1:0] PRI_RESET = 2'h0;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    localparam logic [3:0] DIGIT_RESET = 4'h0;
    localparam logic [7:0] ACC_RESET = 8'h00;

endpackage : swt_pkg

// *** hdl/swt_tick_gen.sv ***
// stopwatch source tick: divides the core clock to one pulse per period
// of the 256 Hz internal source.
// assumes a synchronous active-high reset on core_clk.
module swt_tick_gen
    import swt_pkg::*;
#(
    parameter int unsigned DIV = SRC_DIV_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    output logic tick
);

    logic [31:0] cnt_r;

    // free-running period counter, one-cycle tick at wrap
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cnt_r <= 32'h0;
            tick <= 1'b0;
        end else if (cnt_r == 32'(DIV - 1)) begin
            cnt_r <= 32'h0;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 32'h1;
            tick <= 1'b0;
        end
    end

endmodule : swt_tick_gen

// *** hdl/swt_bcd_digit.sv ***
// one bcd decade of the stopwatch: steps 0 to 9 and wraps.
// assumes step and clear come from logic on the same clock.
module swt_bcd_digit
    import swt_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clear,
    input wire logic step,
    output logic [3:0] digit,
    output logic wrap
);

    // wrap pulses with the step that leaves 9
    assign wrap = step && (digit == BCD_MAX);

    // clear wins over a step in the same cycle
    always_ff @(posedge core_clk) begin
        if (reset || clear) begin
            digit <= DIGIT_RESET;
        end else if (wrap) begin
            digit <= DIGIT_RESET;
        end else if (step) begin
            digit <= digit + 4'h1;
        end
    end

endmodule : swt_bcd_digit

// *** hdl/swt_top.sv ***
// stopwatch timer: two bcd digits (tenths, hundredths) stepped from a
// 256 Hz internal source, with 100/10/1 Hz interrupt factors.
// assumes an avalon-mm master on core_clk and a synchronous reset.
//
// Contract
// - run bit in control bit 0 runs counter; 0 holds; resets to 0.
// - writing 1 to control bit 1 clears both digits; reads back 0.
// - data register shows tenths in bits 7:4, hundredths in 3:0.
// - priority bits 3:2 select level 0 to 3; reset to 00.
// - enable bits 6,5,4 gate 100 Hz, 10 Hz, 1 Hz interrupts.
// - flag bits 6,5,4 set on factors; write 1 clears.
// - after run is cleared, one more source-clock count then halt.
// - factors from that final count still set flags and interrupt.
module swt_top
    import swt_pkg::*;
#(
    parameter int unsigned SRC_DIV = SRC_DIV_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [AV_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    output logic [1:0] sw_irq_level
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic ack_r;
    logic req;
    logic wr_go;
    logic sel_pri;
    logic sel_en;
    logic sel_flag;
    logic sel_ctl;
    logic sel_cnt;
    logic wr_ctl;
    logic clr_now;
    logic sw_run_bit_r;
    logic stop_pend_r;
    logic counting;
    logic src_tick;
    logic advance;
    logic [7:0] acc_r;
    logic [8:0] acc_sum;
    logic hund_step;
    logic hund_wrap;
    logic tenth_wrap;
    logic [3:0] hundredths_digit;
    logic [3:0] tenths_digit;
    logic [2:0] events;
    logic [2:0] irq_enable_r;
    logic [2:0] irq_flag_r;
    logic [2:0] irq_flag_nxt;
    logic [1:0] sw_priority_r;
    logic [7:0] rd_byte;

    // ****************************************************************
    // avalon slave: one wait cycle on every access
    // ****************************************************************

    // request accepted on the edge where waitrequest is low
    assign req = avs_read || avs_write;
    assign avs_waitrequest = req && !ack_r;
    assign wr_go = avs_write && ack_r;

    // address decode, byte address is four times the index
    assign sel_pri = avs_address == AV_ADDR_W'({IDX_PRIORITY, 2'b00});
    assign sel_en = avs_address == AV_ADDR_W'({IDX_ENABLE, 2'b00});
    assign sel_flag = avs_address == AV_ADDR_W'({IDX_FLAGS, 2'b00});
    assign sel_ctl = avs_address == AV_ADDR_W'({IDX_CONTROL, 2'b00});
    assign sel_cnt = avs_address == AV_ADDR_W'({IDX_COUNT, 2'b00});
    assign wr_ctl = wr_go && sel_ctl;

    // wait-cycle acknowledge
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req && !ack_r;
        end
    end

    // read mux; unmapped addresses read as zero
    always_comb begin
        rd_byte = 8'h00;
        if (sel_pri) begin
            rd_byte[PRI_LSB +: 2] = sw_priority_r;
        end else if (sel_en) begin
            rd_byte[IRQ_LSB +: 3] = irq_enable_r;
        end else if (sel_flag) begin
            rd_byte[IRQ_LSB +: 3] = irq_flag_r;
        end else if (sel_ctl) begin
            rd_byte[CTL_RUN_POS] = sw_run_bit_r;
        end else if (sel_cnt) begin
            rd_byte = {tenths_digit, hundredths_digit};
        end
    end

    // read data captured in the wait cycle, held until the next read
    always_ff @(posedge core_clk) begin
        if (reset) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && !ack_r) begin
            avs_readdata <= {24'h0, rd_byte};
        end
    end

    // ****************************************************************
    // control register
    // ****************************************************************

    assign clr_now = wr_ctl && avs_writedata[CTL_CLR_POS];

    always_ff @(posedge core_clk) begin
        if (reset) begin
            sw_run_bit_r <= 1'b0;
        end else if (wr_ctl) begin
            sw_run_bit_r <= avs_writedata[CTL_RUN_POS];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            stop_pend_r <= 1'b0;
        end else if (wr_ctl && avs_writedata[CTL_RUN_POS]) begin
            stop_pend_r <= 1'b0;
        end else if (wr_ctl && sw_run_bit_r && !src_tick) begin
            stop_pend_r <= 1'b1;
        end else if (src_tick) begin
            stop_pend_r <= 1'b0;
        end
    end

    // ****************************************************************
    // counting chain
    // ****************************************************************

    swt_tick_gen #(
        .DIV(SRC_DIV)
    ) u_tick (
        .core_clk(core_clk),
        .reset(reset),
        .tick(src_tick)
    );

    assign counting = sw_run_bit_r || stop_pend_r;
    assign advance = src_tick && counting;

    // rate accumulator, 100 of 256 ticks
    assign acc_sum = {1'b0, acc_r} + {1'b0, STEP_INC};
    assign hund_step = advance && acc_sum[8] && !clr_now;

    // fractional accumulator
    always_ff @(posedge core_clk) begin
        if (reset || clr_now) begin
            acc_r <= ACC_RESET;
        end else if (advance) begin
            acc_r <= acc_sum[7:0];
        end
    end

    swt_bcd_digit u_hund (
        .core_clk(core_clk),
        .reset(reset),
        .clear(clr_now),
        .step(hund_step),
        .digit(hundredths_digit),
        .wrap(hund_wrap)
    );

    swt_bcd_digit u_tenth (
        .core_clk(core_clk),
        .reset(reset),
        .clear(clr_now),
        .step(hund_wrap),
        .digit(tenths_digit),
        .wrap(tenth_wrap)
    );

    // factor events: index 2 is 100 Hz, 1 is 10 Hz, 0 is 1 Hz
    assign events = {hund_step, hund_wrap, tenth_wrap};

    // ****************************************************************
    // interrupt registers
    // ****************************************************************

    always_ff @(posedge core_clk) begin
        if (reset) begin
            sw_priority_r <= PRI_RESET;
        end else if (wr_go && sel_pri) begin
            sw_priority_r <= avs_writedata[PRI_LSB +: 2];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            irq_enable_r <= IRQ_RESET;
        end else if (wr_go && sel_en) begin
            irq_enable_r <= avs_writedata[IRQ_LSB +: 3];
        end
    end

    always_comb begin
        irq_flag_nxt = irq_flag_r;
        if (wr_go && sel_flag) begin
            irq_flag_nxt = irq_flag_nxt & ~avs_writedata[IRQ_LSB +: 3];
        end
        irq_flag_nxt = irq_flag_nxt | events;
    end

    // sticky flags
    always_ff @(posedge core_clk) begin
        if (reset) begin
            irq_flag_r <= IRQ_RESET;
        end else begin
            irq_flag_r <= irq_flag_nxt;
        end
    end

    assign irq = |(irq_flag_r & irq_enable_r);
    assign sw_irq_level = sw_priority_r;

    // ****************************************************************
    // assertions
    // ****************************************************************

    property p_run_hold;
        @(posedge core_clk) disable iff (reset)
        (!counting && !clr_now) |=>
            $stable({tenths_digit, hundredths_digit});
    endproperty
    a_run_hold: assert property (p_run_hold)
        else $error("digits moved while stopped");

    property p_clear;
        @(posedge core_clk) disable iff (reset)
        clr_now |=> (tenths_digit == 4'h0) && (hundredths_digit == 4'h0)
            && (acc_r == 8'h00);
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear did not zero the digits");

    property p_data_read;
        @(posedge core_clk) disable iff (reset)
        (avs_read && ack_r && sel_cnt) |->
            avs_readdata == {24'h0, $past(tenths_digit),
            $past(hundredths_digit)};
    endproperty
    a_data_read: assert property (p_data_read)
        else $error("count read returned wrong digits");

    property p_ctl_read;
        @(posedge core_clk) disable iff (reset)
        (avs_read && ack_r && sel_ctl) |->
            avs_readdata[31:1] == 31'h0;
    endproperty
    a_ctl_read: assert property (p_ctl_read)
        else $error("control read shows unused bits");

    property p_prio;
        @(posedge core_clk) disable iff (reset)
        (wr_go && sel_pri) |=>
            sw_irq_level == $past(avs_writedata[PRI_LSB +: 2]);
    endproperty
    a_prio: assert property (p_prio)
        else $error("priority level not taken from write");

    property p_enable;
        @(posedge core_clk) disable iff (reset)
        (wr_go && sel_en) |=>
            irq_enable_r == $past(avs_writedata[IRQ_LSB +: 3]);
    endproperty
    a_enable: assert property (p_enable)
        else $error("enable bits not taken from write");

    property p_flag_set;
        @(posedge core_clk) disable iff (reset)
        (hund_step && wr_go && sel_flag && avs_writedata[IRQ_LSB + 2]) |=>
            irq_flag_r[2];
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("event lost against a flag clear");

    property p_flag_clr;
        @(posedge core_clk) disable iff (reset)
        (wr_go && sel_flag && avs_writedata[IRQ_LSB + 1] && !hund_wrap) |=>
            !irq_flag_r[1];
    endproperty
    a_flag_clr: assert property (p_flag_clr)
        else $error("write one did not clear the flag");

    property p_final;
        @(posedge core_clk) disable iff (reset)
        (stop_pend_r && src_tick && !sw_run_bit_r && !clr_now) |=>
            (acc_r == $past(acc_sum[7:0])) &&
            (counting == $past(wr_ctl && avs_writedata[CTL_RUN_POS]));
    endproperty
    a_final: assert property (p_final)
        else $error("final count not taken before halt");

    property p_irq;
        @(posedge core_clk) disable iff (reset)
        (events[0] && irq_enable_r[0] && !(wr_go && sel_en)) |=> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("enabled factor raised no interrupt");

    property p_carry;
        @(posedge core_clk) disable iff (reset)
        (hund_wrap && !clr_now) |=> (hundredths_digit == 4'h0) &&
            (tenths_digit != $past(tenths_digit));
    endproperty
    a_carry: assert property (p_carry)
        else $error("hundredths wrap did not carry");

endmodule : swt_top

// *** test/swt_top_tb.sv ***
// stopwatch timer testbench: register, counting, stop and interrupt checks.
// assumes swt_top with a shortened source divider and one 25 MHz clock.
module swt_top_tb
    import swt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned DIV = 8; // short source period for simulation
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [AV_ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic irq;
    logic [1:0] sw_irq_level;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    int steps;
    logic [31:0] last, a, b;

    swt_top #(.SRC_DIV(DIV)) i_swt_top (
        .core_clk(core_clk),
        .reset(reset),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .irq(irq),
        .sw_irq_level(sw_irq_level)
    );

    // 40 ns core clock and a free cycle count
    initial begin
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) cyc <= cyc + 1;

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic final_report();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    task automatic chk_reg(string nm, logic [31:0] exp, logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_reg

    task automatic chk_out(string nm, logic [1:0] exp, logic [1:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_out

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(logic is_wr, logic [15:0] idx, logic [7:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        avs_address <= {idx, 2'b00};
        avs_write <= is_wr;
        avs_read <= !is_wr;
        avs_writedata <= {24'h0, wd};
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            n_fail++;
            $display("Error waitrequest expected 0 seen 1");
            final_report();
        end
        @(posedge core_clk);
    endtask : bus

    task automatic wr(logic [15:0] idx, logic [7:0] wd);
        logic [31:0] d;
        bus(1'b1, idx, wd, d);
    endtask : wr

    task automatic rd_chk(string nm, logic [15:0] idx, logic [7:0] exp);
        logic [31:0] d;
        bus(1'b0, idx, 8'h00, d);
        chk_reg(nm, {24'h0, exp}, d);
    endtask : rd_chk

    function automatic logic [7:0] bcd_inc(logic [7:0] v);
        if (v[3:0] != BCD_MAX) return {v[7:4], v[3:0] + 4'h1};
        return {(v[7:4] == BCD_MAX) ? 4'h0 : v[7:4] + 4'h1, 4'h0};
    endfunction : bcd_inc

    function automatic int bcd_val(logic [7:0] v);
        return v[7:4] * 10 + v[3:0];
    endfunction : bcd_val

    // follow the count, each change must be one bcd step
    task automatic poll(int ncyc, output int n);
        logic [31:0] prev, cur;
        int t0;
        n = 0;
        t0 = cyc;
        bus(1'b0, IDX_COUNT, 8'h00, prev);
        while (cyc - t0 < ncyc) begin
            bus(1'b0, IDX_COUNT, 8'h00, cur);
            if (cur !== prev) begin
                chk_reg("count step", {24'h0, bcd_inc(prev[7:0])}, cur);
                n++;
                prev = cur;
            end
        end
    endtask : poll

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        rd_chk("priority", IDX_PRIORITY, 8'h00);
        rd_chk("enable", IDX_ENABLE, 8'h00);
        rd_chk("flags", IDX_FLAGS, 8'h00);
        rd_chk("control", IDX_CONTROL, 8'h00);
        rd_chk("count", IDX_COUNT, 8'h00);
        chk_out("irq", 2'h0, {1'b0, irq});
        wr(16'hff30, 8'hff);
        rd_chk("unmapped", 16'hff30, 8'h00);
        // every priority code reaches the level output
        for (int i = 0; i < 4; i++) begin
            wr(IDX_PRIORITY, 8'(i * 4) | 8'hf3);
            rd_chk("priority", IDX_PRIORITY, 8'(i * 4));
            chk_out("level", 2'(i), sw_irq_level);
        end
        wr(IDX_ENABLE, 8'hff);
        rd_chk("enable", IDX_ENABLE, 8'h70);
        wr(IDX_ENABLE, 8'h00);
        wr(IDX_COUNT, 8'h55);
        rd_chk("count", IDX_COUNT, 8'h00);
        // run with clear, clear reads back 0
        wr(IDX_CONTROL, 8'hff);
        rd_chk("control", IDX_CONTROL, 8'h01);
        poll(2200, steps);
        a = 32'(2200 * STEP_HZ / (SRC_CLK_HZ * DIV));
        chk_out("step rate", 2'h1, {1'b0, steps >= a - 2 && steps <= a + 2});
        rd_chk("flags", IDX_FLAGS, 8'h70);
        // stop: at most the final count, then hold
        bus(1'b0, IDX_COUNT, 8'h00, last);
        wr(IDX_CONTROL, 8'h00);
        repeat (4 * DIV) @(posedge core_clk);
        bus(1'b0, IDX_COUNT, 8'h00, a);
        wr(IDX_FLAGS, 8'h70);
        repeat (4 * DIV) @(posedge core_clk);
        bus(1'b0, IDX_COUNT, 8'h00, b);
        chk_reg("held count", a, b);
        steps = (bcd_val(a[7:0]) - bcd_val(last[7:0]) + 100) % 100;
        chk_out("final count", 2'h1, {1'b0, steps <= 2});
        rd_chk("flags halted", IDX_FLAGS, 8'h00);
        // resume without clear to collect all three factors, enabled;
        // clearing only the 100 Hz flag meets its events on the way
        wr(IDX_ENABLE, 8'h70);
        wr(IDX_CONTROL, 8'h01);
        repeat (600) wr(IDX_FLAGS, 8'h40);
        repeat (300) @(posedge core_clk);
        wr(IDX_CONTROL, 8'h00);
        repeat (4 * DIV) @(posedge core_clk);
        rd_chk("flags", IDX_FLAGS, 8'h70);
        chk_out("irq run", 2'h1, {1'b0, irq});
        wr(IDX_ENABLE, 8'h00);
        chk_out("irq masked", 2'h0, {1'b0, irq});
        wr(IDX_ENABLE, 8'h10);
        chk_out("irq 1hz", 2'h1, {1'b0, irq});
        wr(IDX_FLAGS, 8'h40);
        rd_chk("flags one", IDX_FLAGS, 8'h30);
        wr(IDX_FLAGS, 8'h00);
        rd_chk("flags zero", IDX_FLAGS, 8'h30);
        wr(IDX_FLAGS, 8'h10);
        rd_chk("flags", IDX_FLAGS, 8'h20);
        chk_out("irq cleared", 2'h0, {1'b0, irq});
        wr(IDX_ENABLE, 8'h20);
        chk_out("irq 10hz", 2'h1, {1'b0, irq});
        wr(IDX_FLAGS, 8'h20);
        chk_out("irq off", 2'h0, {1'b0, irq});
        // clear while stopped
        wr(IDX_CONTROL, 8'h02);
        rd_chk("count cleared", IDX_COUNT, 8'h00);
        rd_chk("control", IDX_CONTROL, 8'h00);
        final_report();
    end
endmodule : swt_top_tb
